/* File: fbd_pkg.sv */
// Package for the flash bus address decoder and its requester end.
// Assumes a single 100 MHz clock domain shared by both ends.
package fbd_pkg;
  // Address space geometry
  localparam int ADDR_W = 24;
  localparam int SEG_W = 8;
  localparam int PAGE_W = 2;
  localparam int DATA_W = 16;
  localparam int SEG_COUNT = 256;
  localparam int PAGE_BYTES = 16384;
  // Window layout, in 64 Kbyte segments
  localparam logic [7:0] SEG_ZERO = 8'h00;
  localparam logic [7:0] SEG_ONE = 8'h01;
  localparam logic [7:0] SEG_BLK5 = 8'h02;
  localparam logic [7:0] SEG_BLK7 = 8'h04;
  localparam logic [7:0] SEG_RSV_LO = 8'h05;
  localparam logic [7:0] SEG_RSV_HI = 8'h07;
  localparam logic [7:0] SEG_REGS = 8'h08;
  // Split inside a segment between the 8K blocks and the 32K block
  localparam int LOW_HALF_BIT = 15;
  // Flash array depth in words (256 Kbytes)
  localparam int FLASH_WORDS = 131072;
  localparam int FLASH_IDX_W = 17;
  // Control register area depth in words
  localparam int REG_WORDS = 8;
  localparam int REG_IDX_W = 3;
  // Trap opcode returned from reserved space
  localparam logic [15:0] TRAP_OPCODE = 16'h009b;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int ZERO_WAIT_MAX_MHZ = 64;
  localparam int READ_WAIT_STATES = 0;
  // Addressing mode of a request
  typedef enum logic [1:0] {
    FBD_AM_INDIRECT,
    FBD_AM_LONG16,
    FBD_AM_SHORT,
    FBD_AM_BIT
  } fbd_amode_t;
  // Requester kind
  typedef enum logic [1:0] {
    FBD_SRC_FETCH,
    FBD_SRC_DATA,
    FBD_SRC_EVENT
  } fbd_src_t;
  // Region of a decoded address
  typedef enum logic [2:0] {
    FBD_RG_FLASH,
    FBD_RG_RESERVED,
    FBD_RG_REGS,
    FBD_RG_OUTSIDE
  } fbd_region_t;
endpackage

/* File: fbd_if.sv */
// Interface joining the requester end and the flash decoder end.
// Assumes both ends share clk; no clocking block.
`timescale 1ns/100ps
`default_nettype none
interface fbd_if;
  import fbd_pkg::*;
  // Request
  logic req_valid;
  logic req_write;
  logic req_byte;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata;
  fbd_src_t req_src;
  fbd_amode_t req_amode;
  // Answer
  logic rsp_valid;
  logic [DATA_W-1:0] rsp_rdata;
  logic rsp_error;
  logic rsp_hit;
  // Decoder side
  modport dev (
    input req_valid, req_write, req_byte, req_addr, req_wdata, req_src, req_amode,
    output rsp_valid, rsp_rdata, rsp_error, rsp_hit
  );
  // Requester side
  modport req (
    output req_valid, req_write, req_byte, req_addr, req_wdata, req_src, req_amode,
    input rsp_valid, rsp_rdata, rsp_error, rsp_hit
  );
endinterface
`default_nettype wire

/* File: fbd_decoder.sv */
// Flash window decoder: maps requests onto flash array, reserved area and
// control registers. Assumes requests synchronous to clk, one per cycle.
// The preload port stands in for the programming path, which is not modelled.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - 16 Mbyte space, 256 segments, 16K pages
// - Word low byte at even address
// - Double words as two ascending words
// - Bit 0 even byte, bit 15 odd
// - Requester keeps units inside one area
// - 512K window: flash, reserved, registers
// - Block layout by segment, registers at 08'0000h
// - Remap selector moves first 32K segment
// - Zero wait state flash reads
// - Writes accepted only in register area
// - Requester writes not from flash fetches
// - Register writes only with indirect addressing
// - Fetches and word accesses use even addresses
// - Code ends with unconditional branch
// - Data reads only indirect or long
// - Event transfers ignore data page pointer
// - No bit addressing of flash
// - Reserved reads return trap opcode
// - Reserved writes change nothing
module fbd_decoder import fbd_pkg::*; #(
  parameter int FLASH_DEPTH = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Configuration
  input wire logic internal_flash_enable,
  input wire logic flash_low_remap_select,
  // Flash array preload port
  input wire logic load_valid,
  input wire logic [FLASH_IDX_W-1:0] load_index,
  input wire logic [DATA_W-1:0] load_data,
  // Control register view
  output logic [REG_WORDS*DATA_W-1:0] ctrl_regs,
  // Request link
  fbd_if.dev bus
);
  // Elaboration checks: depth must fit the array, reads need no wait
  if (FLASH_DEPTH < 1 || FLASH_DEPTH > FLASH_WORDS) begin : g_depth_bad
    $error("FLASH_DEPTH out of range");
  end
  if (ZERO_WAIT_MAX_MHZ < 1 || READ_WAIT_STATES != 0) begin : g_wait_bad
    $error("Read timing not served");
  end
  localparam int FIDX_W = $clog2(FLASH_DEPTH) > 0 ? $clog2(FLASH_DEPTH) : 1;

  // Whole state of the module
  // Flash words live here too, so preload and bus share one
  // register stage and no second writer exists
  typedef struct packed {
    logic [FLASH_DEPTH-1:0][DATA_W-1:0] flash;
    logic [REG_WORDS-1:0][DATA_W-1:0] regs;
    logic rsp_valid;
    logic [DATA_W-1:0] rsp_rdata;
    logic rsp_error;
    logic rsp_hit;
  } fbd_dec_state_t;

  fbd_dec_state_t st; // Registered state
  fbd_dec_state_t next_st; // Next state
  fbd_region_t region; // Decoded region
  logic [FLASH_IDX_W-1:0] fidx; // Word index into flash
  logic [REG_IDX_W-1:0] ridx; // Word index into registers
  logic [SEG_W-1:0] seg; // Segment field
  logic [DATA_W-1:0] word; // Word at the index
  logic bad; // Illegal access

  // Address decode of the 512 Kbyte window
  // Only segments 0 to 8 decode; anything above misses with hit low
  // With the enable low the whole window reads as empty
  // The remap selector never moves the 32K block at 01'8000h
  always_comb begin
    seg = bus.req_addr[ADDR_W-1 -: SEG_W];
    region = FBD_RG_OUTSIDE;
    fidx = '0;
    ridx = bus.req_addr[REG_IDX_W:1];
    // Upper half of segment 0 falls through every branch and misses
    if (internal_flash_enable) begin
      if (seg == SEG_ZERO && !bus.req_addr[LOW_HALF_BIT]) begin
        // First 32K sits in segment 0 unless remapped
        if (!flash_low_remap_select) begin
          region = FBD_RG_FLASH;
          fidx = {2'b00, bus.req_addr[LOW_HALF_BIT:1]};
        end
      end else if (seg == SEG_ONE && !bus.req_addr[LOW_HALF_BIT]) begin
        // Remapped copy of the first 32K in segment 1
        if (flash_low_remap_select) begin
          region = FBD_RG_FLASH;
          fidx = {2'b00, bus.req_addr[LOW_HALF_BIT:1]};
        end
      end else if (seg == SEG_ONE) begin
        // 32K block at 01'8000h
        region = FBD_RG_FLASH;
        fidx = {2'b00, bus.req_addr[LOW_HALF_BIT:1]};
      end else if (seg >= SEG_BLK5 && seg <= SEG_BLK7) begin
        // Three 64K blocks
        region = FBD_RG_FLASH;
        fidx = {seg[1:0] - 2'b01, bus.req_addr[LOW_HALF_BIT:1]};
        // Reserved segments answer but never store
      end else if (seg >= SEG_RSV_LO && seg <= SEG_RSV_HI) begin
        region = FBD_RG_RESERVED;
        // Control registers, mirrored every 16 bytes
      end else if (seg == SEG_REGS) begin
        region = FBD_RG_REGS;
      end
    end
  end

  // Access legality
  // A refused access leaves state untouched and answers zero data
  // with the error flag; the requester end filters most of these,
  // but this end must not rely on it
  always_comb begin
    bad = 1'b0;
    // Word access and fetch must be even
    if ((!bus.req_byte || bus.req_src == FBD_SRC_FETCH) && bus.req_addr[0])
      bad = 1'b1;
    // Flash has no short or bit addressing; event transfers use own pointers
    if (region == FBD_RG_FLASH && bus.req_src == FBD_SRC_DATA &&
        (bus.req_amode == FBD_AM_SHORT || bus.req_amode == FBD_AM_BIT))
      bad = 1'b1;
    // Bit operations never reach flash, whoever asks
    if (region == FBD_RG_FLASH && bus.req_amode == FBD_AM_BIT)
      bad = 1'b1;
    // Register writes need indirect addressing
    if (bus.req_write && region == FBD_RG_REGS && bus.req_amode != FBD_AM_INDIRECT)
      bad = 1'b1;
  end

  // Read word selection with little-endian byte lanes
  // Words past FLASH_DEPTH read as zero rather than wrapping,
  // so a short model never aliases upper blocks onto block zero
  // Byte lanes are picked later, in the answer
  always_comb begin
    word = ZERO_WORD;
    if (region == FBD_RG_FLASH && fidx < FLASH_IDX_W'(FLASH_DEPTH))
      word = st.flash[fidx[FIDX_W-1:0]];
    else if (region == FBD_RG_REGS)
      word = st.regs[ridx];
    else if (region == FBD_RG_RESERVED)
      word = TRAP_OPCODE;
  end

  // Next state
  // One request per cycle, answered at the next edge with no wait
  // Read data stands until the next answer; pulses drop after one
  // Preload and bus write never touch the same storage, so no
  // priority between them is needed
  always_comb begin
    next_st = st;
    next_st.rsp_valid = bus.req_valid; // Zero wait: answer next edge
    next_st.rsp_error = 1'b0;
    next_st.rsp_hit = 1'b0;
    if (load_valid && load_index < FLASH_IDX_W'(FLASH_DEPTH))
      next_st.flash[load_index[FIDX_W-1:0]] = load_data;
    if (bus.req_valid) begin
      next_st.rsp_hit = region != FBD_RG_OUTSIDE;
      next_st.rsp_error = bad;
      if (bus.req_write) begin
        next_st.rsp_rdata = ZERO_WORD;
        // Only the register area takes writes; flash and reserved ignore
        if (region == FBD_RG_REGS && !bad) begin
          // Byte write lands in the lane its address picks
          if (!bus.req_byte)
            next_st.regs[ridx] = bus.req_wdata;
          else if (bus.req_addr[0])
            next_st.regs[ridx][15:8] = bus.req_wdata[7:0];
          else
            next_st.regs[ridx][7:0] = bus.req_wdata[7:0];
        end
      end else if (bad) begin
        next_st.rsp_rdata = ZERO_WORD;
      end else if (bus.req_byte && region != FBD_RG_RESERVED) begin
        // Odd byte is the high half of the word
        next_st.rsp_rdata = bus.req_addr[0] ? {8'h00, word[15:8]}
                                            : {8'h00, word[7:0]};
      end else begin
        next_st.rsp_rdata = word;
      end
    end
  end

  // State register
  // Reset clears the answer and control registers only; the array
  // keeps its contents, as nonvolatile storage would
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
      st.flash <= next_st.flash; // Array contents survive reset
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  // All link outputs come straight from flops
  assign bus.rsp_valid = st.rsp_valid;
  assign bus.rsp_rdata = st.rsp_rdata;
  assign bus.rsp_error = st.rsp_error;
  assign bus.rsp_hit = st.rsp_hit;
  assign ctrl_regs = st.regs;
endmodule
`default_nettype wire

/* File: fbd_requester.sv */
// Requester end: issues one access per legal command, two for a double, and waits for the answer.
// Splits double-word fetches into two ascending word fetches.
`timescale 1ns/100ps
`default_nettype none
module fbd_requester import fbd_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // User command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic cmd_byte,
  input wire logic cmd_double,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_wdata,
  input wire fbd_src_t cmd_src,
  input wire fbd_amode_t cmd_amode,
  input wire logic fetching_from_flash,
  // User answer
  output logic done,
  output logic [2*DATA_W-1:0] done_data,
  output logic done_error,
  // Request link
  fbd_if.req bus
);
  typedef enum {FBD_Q_IDLE, FBD_Q_WAIT, FBD_Q_WAIT2} fbd_q_t;
  // Whole state
  typedef struct packed {
    fbd_q_t phase;
    logic second; // Waiting on the upper word of a double
    logic req_valid;
    logic req_write;
    logic req_byte;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_wdata;
    fbd_src_t req_src;
    fbd_amode_t req_amode;
    logic done;
    logic [2*DATA_W-1:0] done_data;
    logic done_error;
  } fbd_req_state_t;
  fbd_req_state_t st; // Registered state
  fbd_req_state_t next_st; // Next state
  logic legal; // Command allowed
  localparam int PAGE_TOP = $clog2(PAGE_BYTES) - 1; // Top offset bit in a page

  // Command legality seen by the requester
  always_comb begin
    legal = 1'b1;
    if (cmd_write && fetching_from_flash)
      legal = 1'b0;
    if (cmd_write && cmd_amode != FBD_AM_INDIRECT)
      legal = 1'b0;
    if ((!cmd_byte || cmd_src == FBD_SRC_FETCH) && cmd_addr[0])
      legal = 1'b0;
    // Second word must stay within the same page, hence segment
    if (cmd_double && cmd_addr[PAGE_TOP:1] == '1)
      legal = 1'b0;
  end

  assign cmd_ready = st.phase == FBD_Q_IDLE;

  // Next state
  always_comb begin
    next_st = st;
    next_st.req_valid = 1'b0;
    next_st.done = 1'b0;
    case (st.phase)
      FBD_Q_IDLE: begin
        if (cmd_valid && !legal) begin
          next_st.done = 1'b1;
          next_st.done_error = 1'b1;
          next_st.done_data = '0;
        end else if (cmd_valid) begin
          next_st.req_valid = 1'b1;
          next_st.req_write = cmd_write;
          next_st.req_byte = cmd_byte && !cmd_double;
          next_st.req_addr = cmd_addr;
          next_st.req_wdata = cmd_wdata;
          next_st.req_src = cmd_double ? FBD_SRC_FETCH : cmd_src;
          next_st.req_amode = cmd_amode;
          next_st.done_error = 1'b0;
          next_st.second = 1'b0;
          next_st.phase = cmd_double ? FBD_Q_WAIT2 : FBD_Q_WAIT;
        end
      end
      FBD_Q_WAIT2: begin
        if (bus.rsp_valid) begin
          // First word low, next word at address plus two
          next_st.done_data[DATA_W-1:0] = bus.rsp_rdata;
          next_st.done_error = bus.rsp_error;
          next_st.req_valid = 1'b1;
          next_st.req_addr = st.req_addr + ADDR_W'(2);
          next_st.phase = FBD_Q_WAIT;
          next_st.second = 1'b1;
        end
      end
      FBD_Q_WAIT: begin
        if (bus.rsp_valid) begin
          if (st.second)
            next_st.done_data[2*DATA_W-1:DATA_W] = bus.rsp_rdata;
          else
            next_st.done_data = {ZERO_WORD, bus.rsp_rdata};
          next_st.done_error = st.done_error | bus.rsp_error;
          next_st.done = 1'b1;
          next_st.phase = FBD_Q_IDLE;
        end
      end
      default: next_st.phase = FBD_Q_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

  // Outputs
  assign bus.req_valid = st.req_valid;
  assign bus.req_write = st.req_write;
  assign bus.req_byte = st.req_byte;
  assign bus.req_addr = st.req_addr;
  assign bus.req_wdata = st.req_wdata;
  assign bus.req_src = st.req_src;
  assign bus.req_amode = st.req_amode;
  assign done = st.done;
  assign done_data = st.done_data;
  assign done_error = st.done_error;
endmodule
`default_nettype wire

/* File: fbd_props.sv */
// Checker for the link between requester end and decoder end.
// Assumes it sits beside the interface, fed its signals by name.
`timescale 1ns/100ps
`default_nettype none
module fbd_props import fbd_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_byte,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire fbd_src_t req_src,
  input wire fbd_amode_t req_amode,
  // Answer
  input wire logic rsp_valid,
  input wire logic [DATA_W-1:0] rsp_rdata,
  input wire logic rsp_error,
  input wire logic rsp_hit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Segment of the request
  logic [SEG_W-1:0] seg;
  assign seg = req_addr[ADDR_W-1 -: SEG_W];
  // Upper flash blocks and reserved area
  logic in_blk;
  logic in_rsv;
  assign in_blk = seg >= SEG_BLK5 && seg <= SEG_BLK7;
  assign in_rsv = seg >= SEG_RSV_LO && seg <= SEG_RSV_HI;
  // Request taken, answer one cycle on
  sequence s_take; req_valid; endsequence
  sequence s_reply; ##1 rsp_valid; endsequence
  a_answer_next: assert property (s_take |-> s_reply)
    else $error("answer not one cycle after request");
  a_idle_quiet: assert property (!req_valid |=> !rsp_valid)
    else $error("answer without request");
  a_trap_reserved: assert property (s_take ##0 (!req_write && !req_byte && in_rsv)
    |=> !rsp_hit || rsp_rdata == TRAP_OPCODE) else $error("reserved read not trap");
  a_rsv_write_quiet: assert property (req_valid && req_write && in_rsv
    |=> rsp_rdata == ZERO_WORD) else $error("reserved write answered data");
  a_short_refused: assert property (req_valid && req_src == FBD_SRC_DATA
    && req_amode == FBD_AM_SHORT && in_blk |=> rsp_error || !rsp_hit)
    else $error("short flash read accepted");
  a_bit_refused: assert property (req_valid && req_amode == FBD_AM_BIT && in_blk
    |=> rsp_error || !rsp_hit) else $error("bit access to flash accepted");
  a_outside_miss: assert property (req_valid && seg > SEG_REGS |=> !rsp_hit)
    else $error("hit outside window");
  a_event_free: assert property (req_valid && req_src == FBD_SRC_EVENT && !req_write
    && req_amode == FBD_AM_SHORT && seg <= SEG_BLK7 |=> !rsp_error)
    else $error("event transfer refused");
endmodule
`default_nettype wire

/* File: fbd_test.sv */
// Testbench joining requester and decoder ends over the link.
// Assumes package, interface, both ends and checker compiled before.
`timescale 1ns/100ps
`default_nettype none
module fbd_test import fbd_pkg::*;;
  // Clock, reset and configuration
  logic clk, rstn, internal_flash_enable, flash_low_remap_select, fetching_from_flash;
  // Preload port and register view
  logic load_valid;
  logic [FLASH_IDX_W-1:0] load_index;
  logic [DATA_W-1:0] load_data, cmd_wdata;
  logic [REG_WORDS*DATA_W-1:0] ctrl_regs;
  // Command side
  logic cmd_valid, cmd_ready, cmd_write, cmd_byte, cmd_double, done, done_error, got_e;
  logic [ADDR_W-1:0] cmd_addr;
  logic [2*DATA_W-1:0] done_data, got_d;
  fbd_src_t cmd_src;
  fbd_amode_t cmd_amode;
  int error_cnt, n_checks;
  fbd_if bus();
  fbd_decoder #(.FLASH_DEPTH(64)) u_fbd_decoder (.clk, .rstn, .internal_flash_enable,
    .flash_low_remap_select, .load_valid, .load_index, .load_data, .ctrl_regs, .bus(bus));
  fbd_requester u_fbd_requester (.clk, .rstn, .cmd_valid, .cmd_ready, .cmd_write, .cmd_byte,
    .cmd_double, .cmd_addr, .cmd_wdata, .cmd_src, .cmd_amode, .fetching_from_flash, .done,
    .done_data, .done_error, .bus(bus));
  fbd_props u_fbd_props (.clk, .rstn, .req_valid(bus.req_valid), .req_write(bus.req_write),
    .req_byte(bus.req_byte), .req_addr(bus.req_addr), .req_src(bus.req_src),
    .req_amode(bus.req_amode), .rsp_valid(bus.rsp_valid), .rsp_rdata(bus.rsp_rdata),
    .rsp_error(bus.rsp_error), .rsp_hit(bus.rsp_hit));
  // Free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // One command, held until taken, answer captured
  task automatic run(input logic w, b, d, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] v, input fbd_src_t s, input fbd_amode_t m);
    int k;
    k = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    if (cmd_ready !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t requester never ready", $time);
    end
    {cmd_write, cmd_byte, cmd_double, cmd_addr, cmd_wdata} = {w, b, d, a, v};
    cmd_src = s;
    cmd_amode = m;
    cmd_valid = 1'b1;
    k = 0;
    // Falling edges only: a refused command pulses done one edge on
    do begin
      @(negedge clk);
      cmd_valid = 1'b0;
      k++;
    end while (done !== 1'b1 && k < 20);
    {got_d, got_e} = {done_data, done_error};
    if (done !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t no completion", $time);
    end
  endtask
  // Plain word read
  task automatic rdw(input logic [ADDR_W-1:0] a);
    run(1'b0, 1'b0, 1'b0, a, 16'h0000, FBD_SRC_DATA, FBD_AM_INDIRECT);
  endtask
  // Data compare
  task automatic chk_d(input logic [2*DATA_W-1:0] g, e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t data %h want %h", $time, g, e);
    end
  endtask
  // Error flag compare
  task automatic chk_e(input logic e);
    n_checks++;
    if (got_e !== e) begin
      error_cnt++;
      $display("BAD %0t error flag %b want %b", $time, got_e, e);
    end
  endtask
  // Register view compare
  task automatic chk_r(input logic [REG_WORDS*DATA_W-1:0] e);
    n_checks++;
    if (ctrl_regs !== e) begin
      error_cnt++;
      $display("BAD %0t registers %h want %h", $time, ctrl_regs, e);
    end
  endtask
  // Byte order, bit order, outside window
  task automatic t_layout;
    rdw(24'h000000);
    chk_d(got_d, 32'h0000a0b0);
    run(1'b0, 1'b1, 1'b0, 24'h000001, 16'h0000, FBD_SRC_DATA, FBD_AM_INDIRECT);
    chk_d(got_d, 32'h000000a0);
    run(1'b0, 1'b1, 1'b0, 24'h000000, 16'h0000, FBD_SRC_DATA, FBD_AM_INDIRECT);
    chk_d(got_d, 32'h000000b0);
    rdw(24'h100000);
    chk_d(got_d, 32'h00000000);
  endtask
  // Double word fetch, two ascending words
  task automatic t_double;
    run(1'b0, 1'b0, 1'b1, 24'h000000, 16'h0000, FBD_SRC_FETCH, FBD_AM_INDIRECT);
    chk_d(got_d, 32'ha1b1a0b0);
    chk_e(1'b0);
  endtask
  // Low 32K moved between segments
  task automatic t_remap;
    @(negedge clk);
    flash_low_remap_select = 1'b1;
    rdw(24'h010002);
    chk_d(got_d, 32'h0000a1b1);
    rdw(24'h000002);
    chk_d(got_d, 32'h00000000);
    @(negedge clk);
    flash_low_remap_select = 1'b0;
  endtask
  // Reserved reads trap, writes vanish
  task automatic t_reserved;
    rdw(24'h050000);
    chk_d(got_d, 32'h0000009b);
    run(1'b0, 1'b0, 1'b0, 24'h07fffe, 16'h0000, FBD_SRC_FETCH, FBD_AM_INDIRECT);
    chk_d(got_d, 32'h0000009b);
    run(1'b1, 1'b0, 1'b0, 24'h060000, 16'hffff, FBD_SRC_DATA, FBD_AM_INDIRECT);
    chk_r(128'h0);
    rdw(24'h060000);
    chk_d(got_d, 32'h0000009b);
  endtask
  // Writes only to the register area, indirect, not while fetching
  task automatic t_write_area;
    run(1'b1, 1'b0, 1'b0, 24'h080002, 16'h5a5a, FBD_SRC_DATA, FBD_AM_INDIRECT);
    chk_r(128'h5a5a0000);
    rdw(24'h080012);
    chk_d(got_d, 32'h00005a5a);
    run(1'b1, 1'b0, 1'b0, 24'h000000, 16'hffff, FBD_SRC_DATA, FBD_AM_INDIRECT);
    rdw(24'h000000);
    chk_d(got_d, 32'h0000a0b0);
    run(1'b1, 1'b0, 1'b0, 24'h080000, 16'h1234, FBD_SRC_DATA, FBD_AM_LONG16);
    chk_e(1'b1);
    fetching_from_flash = 1'b1;
    run(1'b1, 1'b0, 1'b0, 24'h080000, 16'h1234, FBD_SRC_DATA, FBD_AM_INDIRECT);
    chk_e(1'b1);
    chk_r(128'h5a5a0000);
    fetching_from_flash = 1'b0;
  endtask
  // Odd, short and bit accesses refused, event bit included; event short transfers free
  task automatic t_refused;
    rdw(24'h000001);
    chk_e(1'b1);
    run(1'b0, 1'b0, 1'b0, 24'h000003, 16'h0000, FBD_SRC_FETCH, FBD_AM_INDIRECT);
    chk_e(1'b1);
    run(1'b0, 1'b0, 1'b0, 24'h020000, 16'h0000, FBD_SRC_DATA, FBD_AM_SHORT);
    chk_e(1'b1);
    run(1'b0, 1'b0, 1'b0, 24'h020000, 16'h0000, FBD_SRC_DATA, FBD_AM_BIT);
    chk_e(1'b1);
    run(1'b0, 1'b0, 1'b0, 24'h020000, 16'h0000, FBD_SRC_EVENT, FBD_AM_BIT);
    chk_e(1'b1);
    run(1'b0, 1'b0, 1'b0, 24'h000000, 16'h0000, FBD_SRC_FETCH, FBD_AM_BIT);
    chk_e(1'b1);
    run(1'b0, 1'b0, 1'b0, 24'h000002, 16'h0000, FBD_SRC_DATA, FBD_AM_LONG16);
    chk_d(got_d, 32'h0000a1b1);
    run(1'b0, 1'b0, 1'b0, 24'h000004, 16'h0000, FBD_SRC_EVENT, FBD_AM_SHORT);
    chk_d(got_d, 32'h0000a2b2);
    @(negedge clk);
    internal_flash_enable = 1'b0;
    rdw(24'h000000);
    chk_d(got_d, 32'h00000000);
    @(negedge clk);
    internal_flash_enable = 1'b1;
  endtask
  // Units kept inside one page; code never runs off the array end
  task automatic t_bounds;
    run(1'b0, 1'b0, 1'b1, 24'h003ffe, 16'h0000, FBD_SRC_FETCH, FBD_AM_INDIRECT);
    chk_e(1'b1);
    run(1'b0, 1'b0, 1'b1, 24'h04fffe, 16'h0000, FBD_SRC_FETCH, FBD_AM_INDIRECT);
    chk_e(1'b1);
    run(1'b0, 1'b0, 1'b1, 24'h000002, 16'h0000, FBD_SRC_FETCH, FBD_AM_INDIRECT);
    chk_d(got_d, 32'ha2b2a1b1);
    chk_e(1'b0);
    run(1'b0, 1'b0, 1'b0, 24'h000004, 16'h0000, FBD_SRC_FETCH, FBD_AM_INDIRECT);
    chk_d(got_d, 32'h0000a2b2);
    rdw(24'h090000);
    chk_d(got_d, 32'h00000000);
  endtask
  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence: reset, preload three words, scenarios
  initial begin
    {rstn, load_valid, cmd_valid, cmd_write, cmd_byte, cmd_double} = 6'h00;
    {internal_flash_enable, flash_low_remap_select, fetching_from_flash} = 3'b100;
    {load_index, load_data, cmd_addr, cmd_wdata} = '0;
    cmd_src = FBD_SRC_DATA;
    cmd_amode = FBD_AM_INDIRECT;
    {error_cnt, n_checks} = 64'h0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      {load_valid, load_index} = {1'b1, 17'(i)};
      load_data = 16'ha0b0 + 16'(i) * 16'h0101;
    end
    @(negedge clk);
    load_valid = 1'b0;
    t_layout();
    t_double();
    t_remap();
    t_reserved();
    t_write_area();
    t_refused();
    t_bounds();
    stop_test();
  end
  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
